/* psls_supervisor.sv */
// top of the pfc standby / external latch supervisor
// assumes comparator outputs arrive asynchronously; one 200 MHz clock
// What this block does
// [RQ1] latch input trip enters permanent latched fault
// [RQ2] latched: gate off, pfc off, clamp supply
// [RQ3] latch clears only when supply below 4V
// [RQ4] standby request while sense below reference
// [RQ5] request rising edge restarts confirmation timer
// [RQ6] request still high at expiry: open switch
// [RQ7] request drop closes switch at once
// [RQ8] startup: switch closes when peak flag falls
// [RQ9] short circuit: delay, then stop, hiccup
// [RQ10] hiccup never closes the pfc switch
// [RQ11] undervoltage stops pulses and pfc together
// [RQ12] line loss stops pulses, holds switch open
// [RQ13] line return runs clean startup first
// [RQ14] pfc stays off until startup completes
// [RQ15] confirmation length is a cycle parameter
// [RQ16] latched fault overrides every other mode
`timescale 1ns/1ps
module psls_supervisor #(
	parameter int unsigned STANDBY_CYC = psls_pkg::STANDBY_CONFIRM_CYC,
	parameter int unsigned FAULT_CYC   = psls_pkg::FAULT_DELAY_CYC
) (
	// clock and reset
	input  wire logic clock_in,
	input  wire logic rst_n_in,
	// comparator inputs, asynchronous
	input  wire logic latch_trip_in,
	input  wire logic standby_sense_low_in,
	input  wire logic peak_limit_in,
	input  wire logic short_fault_in,
	input  wire logic supply_uv_in,
	input  wire logic supply_below_4v_in,
	input  wire logic line_ok_in,
	// controls
	output logic      gate_drive_out,
	output logic      pfc_supply_switch_out,
	output logic      supply_clamp_out,
	// status
	output logic      standby_request_out,
	output logic      standby_confirmed_out,
	output logic      latched_out
);
	logic [psls_pkg::SYNC_W-1:0]  s1_reg;
	logic [psls_pkg::SYNC_W-1:0]  s2_reg;
	logic [psls_pkg::SYNC_W-1:0]  raw;
	logic                         line1_reg;
	logic                         line2_reg;
	logic                         req_prev_reg;
	logic                         latch_reg;
	logic [psls_pkg::TIMER_W-1:0] fault_cnt_reg;
	logic                         from_run_reg;
	psls_pkg::psls_state_type     state_reg;
	psls_pkg::psls_state_type     state_next;
	logic                         req;
	logic                         fault_done;
	psls_timer_if                 tif ();

	localparam logic [psls_pkg::TIMER_W-1:0] FAULT_LAST =
		psls_pkg::TIMER_W'(FAULT_CYC - 1);

	// packed in the bit order named by the package
	assign raw = {supply_below_4v_in, supply_uv_in, short_fault_in,
		peak_limit_in, standby_sense_low_in, latch_trip_in};

	// two flops per comparator; line_ok resets low-safe as "not ok"
	genvar g;
	generate
		for (g = 0; g < psls_pkg::SYNC_W; g++) begin : g_sync
			always_ff @(posedge clock_in) begin
				if (!rst_n_in) begin
					s1_reg[g] <= psls_pkg::SYNC_RESET[g];
					s2_reg[g] <= psls_pkg::SYNC_RESET[g];
				end else begin
					s1_reg[g] <= raw[g];
					s2_reg[g] <= s1_reg[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			line1_reg <= 1'b0;
			line2_reg <= 1'b0;
		end else begin
			line1_reg <= line_ok_in;
			line2_reg <= line1_reg;
		end
	end

	assign req = s2_reg[psls_pkg::IN_SENSE_LOW]; // [RQ4]

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			req_prev_reg <= 1'b0;
		end else begin
			req_prev_reg <= req;
		end
	end

	// timer length set in cycles so simulation can shorten it
	assign tif.start = req && !req_prev_reg; // [RQ5]
	assign tif.hold  = req;

	psls_confirm_timer #(
		.LEN_CYC (STANDBY_CYC) // [RQ15]
	) u_timer (
		.clock_in (clock_in),
		.rst_n_in (rst_n_in),
		.tif      (tif)
	);

	// power-on reset also clears the latch; trip beats a clear
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			latch_reg <= 1'b0;
		end else if (s2_reg[psls_pkg::IN_LATCH_TRIP]) begin
			latch_reg <= 1'b1; // [RQ1]
		end else if (s2_reg[psls_pkg::IN_BELOW_4V]) begin
			latch_reg <= 1'b0; // [RQ3]
		end
	end

	// counter parks on its last value, so done stays high
	assign fault_done = (fault_cnt_reg == FAULT_LAST);

	always_ff @(posedge clock_in) begin
		if (!rst_n_in || state_reg != psls_pkg::ST_FAULT_WAIT) begin
			fault_cnt_reg <= '0;
		end else if (!fault_done) begin
			fault_cnt_reg <= fault_cnt_reg + 1'b1; // [RQ9]
		end
	end

	always_comb begin
		state_next = state_reg;
		if (s2_reg[psls_pkg::IN_SUPPLY_UV]) begin
			state_next = psls_pkg::ST_UVLO; // [RQ11]
		end else if (!line2_reg) begin
			state_next = psls_pkg::ST_LINE_LOW; // [RQ12]
		end else begin
			case (state_reg)
				psls_pkg::ST_STARTUP: begin
					if (s2_reg[psls_pkg::IN_SHORT]) begin
						state_next = psls_pkg::ST_FAULT_WAIT;
					end else if (!s2_reg[psls_pkg::IN_PEAK_LIMIT]) begin
						state_next = psls_pkg::ST_RUN; // [RQ8]
					end
				end
				psls_pkg::ST_RUN: begin
					if (s2_reg[psls_pkg::IN_SHORT]) begin
						state_next = psls_pkg::ST_FAULT_WAIT;
					end
				end
				psls_pkg::ST_FAULT_WAIT: begin
					if (!s2_reg[psls_pkg::IN_SHORT]) begin
						state_next = psls_pkg::ST_STARTUP;
					end else if (fault_done) begin
						state_next = psls_pkg::ST_HICCUP; // [RQ9]
					end
				end
				psls_pkg::ST_HICCUP: begin
					// restart only through startup, which waits on the flag
					if (!s2_reg[psls_pkg::IN_SHORT]) begin
						state_next = psls_pkg::ST_STARTUP; // [RQ10]
					end
				end
				// clean restart after undervoltage or line loss
				default: state_next = psls_pkg::ST_STARTUP; // [RQ13]
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			state_reg <= psls_pkg::ST_STARTUP;
		end else begin
			state_reg <= state_next;
		end
	end

	// a short met in run keeps the pfc fed until the delay expires;
	// one met in startup never had it closed
	always_ff @(posedge clock_in) begin
		if (!rst_n_in || state_next != psls_pkg::ST_FAULT_WAIT) begin
			from_run_reg <= 1'b0;
		end else if (state_reg == psls_pkg::ST_RUN) begin
			from_run_reg <= 1'b1; // [RQ9]
		end
	end

	// outputs registered from next state so no extra cycle of lag
	always_ff @(posedge clock_in) begin
		if (!rst_n_in || latch_reg) begin
			gate_drive_out        <= 1'b0; // [RQ2] [RQ16]
			pfc_supply_switch_out <= 1'b0; // [RQ2] [RQ16]
		end else begin
			gate_drive_out <= state_next == psls_pkg::ST_STARTUP ||
				state_next == psls_pkg::ST_RUN ||
				state_next == psls_pkg::ST_FAULT_WAIT;
			// only run, or a delay entered from run, closes it
			pfc_supply_switch_out <= (state_next == psls_pkg::ST_RUN ||
				(state_next == psls_pkg::ST_FAULT_WAIT &&
				(state_reg == psls_pkg::ST_RUN || from_run_reg))) &&
				!(req && tif.expired); // [RQ6] [RQ7] [RQ14]
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			supply_clamp_out      <= 1'b0;
			latched_out           <= 1'b0;
			standby_request_out   <= 1'b0;
			standby_confirmed_out <= 1'b0;
		end else begin
			supply_clamp_out      <= latch_reg; // [RQ2]
			latched_out           <= latch_reg;
			standby_request_out   <= req;
			standby_confirmed_out <= req && tif.expired;
		end
	end
endmodule

/* psls_pkg.sv */
// constants and types for the pfc standby / latch supervisor
// assumes a single 200 MHz clock; no other dependencies
package psls_pkg;
	localparam int unsigned CLK_HZ             = 200_000_000;
	localparam int unsigned STANDBY_CONFIRM_MS = 90;
	localparam int unsigned STANDBY_CONFIRM_CYC =
		(CLK_HZ / 1000) * STANDBY_CONFIRM_MS;
	localparam int unsigned FAULT_DELAY_MS     = 100;
	localparam int unsigned FAULT_DELAY_CYC    =
		(CLK_HZ / 1000) * FAULT_DELAY_MS;
	localparam int unsigned TIMER_W            = 32;
	localparam int unsigned SYNC_W             = 6;
	// bit positions inside the synchronised input vector
	localparam int unsigned IN_LATCH_TRIP = 0;
	localparam int unsigned IN_SENSE_LOW  = 1;
	localparam int unsigned IN_PEAK_LIMIT = 2;
	localparam int unsigned IN_SHORT      = 3;
	localparam int unsigned IN_SUPPLY_UV  = 4;
	localparam int unsigned IN_BELOW_4V   = 5;
	localparam logic [5:0] SYNC_RESET = 6'h00;

	typedef enum logic [2:0] {
		ST_STARTUP,
		ST_RUN,
		ST_FAULT_WAIT,
		ST_HICCUP,
		ST_UVLO,
		ST_LINE_LOW
	} psls_state_type;
endpackage

/* psls_timer_if.sv */
// start / hold / expired handshake between supervisor and its timer
// assumes both ends share clock_in
`timescale 1ns/1ps
interface psls_timer_if;
	logic start;
	logic hold;
	logic expired;
	modport timer (input start, input hold, output expired);
	modport user  (output start, output hold, input expired);
endinterface

/* psls_confirm_timer.sv */
// restartable confirmation timer
// assumes start is a one-cycle pulse on clock_in
`timescale 1ns/1ps
module psls_confirm_timer #(
	parameter int unsigned LEN_CYC = psls_pkg::STANDBY_CONFIRM_CYC
) (
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	// control
	psls_timer_if.timer      tif
);
	logic [psls_pkg::TIMER_W-1:0] cnt_reg;
	logic                         done_reg;
	localparam logic [psls_pkg::TIMER_W-1:0] LAST =
		psls_pkg::TIMER_W'(LEN_CYC - 1);

	always_ff @(posedge clock_in) begin
		if (!rst_n_in || tif.start) begin
			cnt_reg <= '0; // [RQ5]
		end else if (tif.hold && !done_reg) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in || tif.start || !tif.hold) begin
			done_reg <= 1'b0;
		end else if (cnt_reg == LAST) begin
			done_reg <= 1'b1; // [RQ6]
		end
	end

	assign tif.expired = done_reg;
endmodule

/* psls_supervisor_props.sv */
// port assertions for the pfc standby / latch supervisor
// assumes binding to psls_supervisor; one clock domain
`timescale 1ns/1ps
module psls_supervisor_props #(
	parameter int unsigned STANDBY_CYC = 20,
	parameter int unsigned FAULT_CYC   = 10
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// comparators
	input wire logic latch_trip_in,
	input wire logic peak_limit_in,
	input wire logic short_fault_in,
	input wire logic supply_uv_in,
	input wire logic supply_below_4v_in,
	input wire logic line_ok_in,
	// block outputs
	input wire logic gate_drive_out,
	input wire logic pfc_supply_switch_out,
	input wire logic supply_clamp_out,
	input wire logic standby_request_out,
	input wire logic standby_confirmed_out,
	input wire logic latched_out
);
	logic [31:0] req_cnt_reg;
	logic [31:0] sc_cnt_reg;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	// run lengths; no wrap within a short run
	always_ff @(posedge clock_in) begin
		req_cnt_reg <= standby_request_out ? req_cnt_reg + 32'h1 : 32'h0;
	end
	always_ff @(posedge clock_in) begin
		sc_cnt_reg <= short_fault_in ? sc_cnt_reg + 32'h1 : 32'h0;
	end
	a_latch_outputs: assert property (
		latched_out |-> supply_clamp_out &&
		!gate_drive_out && !pfc_supply_switch_out) else $error("latch outs");
	a_trip_latches: assert property (
		latch_trip_in[*7] |-> latched_out)
		else $error("trip not latched");
	a_latch_holds: assert property (
		(!supply_below_4v_in)[*5] ##0 latched_out |=> latched_out)
		else $error("latch lost");
	a_confirm_time: assert property (
		$rose(standby_confirmed_out) |->
		req_cnt_reg inside {[STANDBY_CYC - 2 : STANDBY_CYC + 3]})
		else $error("confirm timing");
	a_confirm_opens: assert property (
		standby_confirmed_out[*3] |-> !pfc_supply_switch_out)
		else $error("switch closed in standby");
	a_drop_closes: assert property (
		$fell(standby_confirmed_out) && !standby_request_out &&
		gate_drive_out |-> ##[0:2] pfc_supply_switch_out)
		else $error("switch late after standby");
	a_uv_stops: assert property (
		supply_uv_in[*6] |-> !gate_drive_out && !pfc_supply_switch_out)
		else $error("uv outputs");
	a_line_stops: assert property (
		(!line_ok_in)[*6] |-> !gate_drive_out && !pfc_supply_switch_out)
		else $error("line loss outputs");
	a_short_expiry: assert property (
		sc_cnt_reg == FAULT_CYC + 8 |->
		!gate_drive_out && !pfc_supply_switch_out) else $error("short outputs");
	// latch clear and standby exit may legally close it with the flag high
	a_peak_blocks: assert property (
		(peak_limit_in && !latched_out && !standby_confirmed_out &&
		!pfc_supply_switch_out)[*6] |=> !pfc_supply_switch_out)
		else $error("switch closed with peak flag");
	c_latched: cover property ($rose(latched_out));
	c_confirmed: cover property ($rose(standby_confirmed_out));
	c_short: cover property (sc_cnt_reg == FAULT_CYC + 8);
endmodule
bind psls_supervisor psls_supervisor_props #(.STANDBY_CYC(STANDBY_CYC),
	.FAULT_CYC(FAULT_CYC)) u_props (.clock_in(clock_in),
	.rst_n_in(rst_n_in), .latch_trip_in(latch_trip_in),
	.peak_limit_in(peak_limit_in), .short_fault_in(short_fault_in),
	.supply_uv_in(supply_uv_in), .supply_below_4v_in(supply_below_4v_in),
	.line_ok_in(line_ok_in), .gate_drive_out(gate_drive_out),
	.pfc_supply_switch_out(pfc_supply_switch_out),
	.supply_clamp_out(supply_clamp_out),
	.standby_request_out(standby_request_out),
	.standby_confirmed_out(standby_confirmed_out), .latched_out(latched_out));

/* psls_pfc_model.sv */
// behavioural front-end pfc stage fed through the switch
// assumes the switch is its only supply
`timescale 1ns/1ps
module psls_pfc_model (
	// clock and reset
	input  wire logic clock_in,
	input  wire logic rst_n_in,
	// supply and state
	input  wire logic powered_in,
	output logic      running_out
);
	logic [3:0] up_reg;
	// slow to come up, drops at once without supply
	always_ff @(posedge clock_in) begin
		if (!rst_n_in || !powered_in) begin
			up_reg <= 4'h0;
		end else if (up_reg != 4'hf) begin
			up_reg <= up_reg + 4'h1;
		end
	end
	assign running_out = (up_reg == 4'hf);
endmodule

/* psls_supervisor_test.sv */
// self-checking bench for psls_supervisor
// assumes the props bind and the pfc model compile alongside
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("BAD %0t %h %h", $time, a, b); end end
module psls_supervisor_test;
	logic       clock_in = 1'b0;
	logic       rst_n_in = 1'b0;
	logic [6:0] v        = 7'h44;
	logic       gate, pfc, clamp, req, conf, lat, run;
	int         mismatches = 0;
	int         n_checks   = 0;
	always #2.5 clock_in = ~clock_in;
	psls_supervisor #(.STANDBY_CYC(20), .FAULT_CYC(10)) u_dut (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .latch_trip_in(v[0]),
		.standby_sense_low_in(v[1]), .peak_limit_in(v[2]),
		.short_fault_in(v[3]), .supply_uv_in(v[4]),
		.supply_below_4v_in(v[5]), .line_ok_in(v[6]),
		.gate_drive_out(gate), .pfc_supply_switch_out(pfc),
		.supply_clamp_out(clamp), .standby_request_out(req),
		.standby_confirmed_out(conf), .latched_out(lat));
	psls_pfc_model u_pfc (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.powered_in(pfc), .running_out(run));
	task report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// inputs move one edge, then settle n edges
	task put(input logic [6:0] x, input int n);
		@(posedge clock_in);
		v <= x;
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task gp(input logic g, input logic p);
		`CHK(gate, g);
		`CHK(pfc, p);
	endtask
	// startup with peak flag, then release
	task recover();
		put(7'h44, 8);
		gp(1'b1, 1'b0);
		put(7'h40, 8);
		gp(1'b1, 1'b1);
		$display("test done %0t", $time);
	endtask
	task wait_run();
		int k;
		for (k = 0; k < 50 && run !== 1'b1; k++) @(posedge clock_in);
		#1;
		`CHK(run, 1'b1);
		if (k == 50) report_and_stop();
	endtask
	initial begin
		repeat (16) @(posedge clock_in);
		rst_n_in <= 1'b1;
		recover();
		wait_run();
		put(7'h42, 8);
		`CHK(req, 1'b1);
		put(7'h40, 4);
		// a timer left running from the first request would confirm here
		put(7'h42, 20);
		`CHK(conf, 1'b0);
		put(7'h42, 12);
		gp(1'b1, 1'b0);
		put(7'h40, 3);
		gp(1'b1, 1'b1);
		put(7'h48, 6);
		gp(1'b1, 1'b1);
		// peak flag stays high through the hiccup attempts
		put(7'h4c, 14);
		gp(1'b0, 1'b0);
		recover();
		// undervoltage, then line loss
		for (int i = 0; i < 2; i++) begin
			put(i ? 7'h00 : 7'h50, 6);
			gp(1'b0, 1'b0);
			recover();
		end
		put(7'h41, 8);
		gp(1'b0, 1'b0);
		`CHK(clamp, 1'b1);
		put(7'h42, 30);
		gp(1'b0, 1'b0);
		`CHK(lat, 1'b1);
		put(7'h60, 8);
		`CHK(lat, 1'b0);
		`CHK(clamp, 1'b0);
		$display("test done %0t", $time);
		report_and_stop();
	end
endmodule
